//--- ivp_top.sv
// interrupt vector placement with guarded select change, AXI4-Lite regs
// Overview of operation
// - vector n (2..29) is dispatched at table start plus 2*(n-2) words.
// - every reset cause shares the single reset address.
// - with select set, each vector is its base address plus boot start.
// - the vector stride is two words for every memory size.
// - reset address is boot start when the boot reset fuse is programmed.
// - table starts at 0x0002, or boot start plus 0x0002 when select is set.
// - select clear puts vectors at flash start, set at boot section start.
// - boot section start comes from the boot size fuses.
// - interrupts are held off from unlock until after the instruction following the select write.
// - without a select write, hold-off ends after four cycles.
// - hold-off never alters the core's global interrupt enable.
// - boot vectors plus app lock block interrupts while running app code.
// - app vectors plus boot lock block interrupts while running boot code.
// - control has select at bit 1, unlock at bit 0, reset zero, 6/5/3/2 zero.
// - unlock clears four cycles after set or when select is written.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ivp_top #(
  parameter int ADDR_W = 16
) (
  input  wire  logic                       CLOCK,
  input  wire  logic                       RST,
  input  wire  logic                       AWVALID,
  output var   logic                       AWREADY,
  input  wire  logic [7:0]                 AWADDR,
  input  wire  logic                       WVALID,
  output var   logic                       WREADY,
  input  wire  logic [31:0]                WDATA,
  input  wire  logic [3:0]                 WSTRB,
  output var   logic                       BVALID,
  input  wire  logic                       BREADY,
  output var   logic [1:0]                 BRESP,
  input  wire  logic                       ARVALID,
  output var   logic                       ARREADY,
  input  wire  logic [7:0]                 ARADDR,
  output var   logic                       RVALID,
  input  wire  logic                       RREADY,
  output var   logic [31:0]                RDATA,
  output var   logic [1:0]                 RRESP,
  input  wire  ivp_pkg::fuse_type          FUSES,
  input  wire  logic [ivp_pkg::NUM_IRQ-1:0] IRQ_REQ,
  input  wire  logic                       GLOBAL_IE,
  input  wire  logic                       EXEC_IN_BOOT,
  input  wire  logic                       INSTR_DONE,
  output var   ivp_pkg::dispatch_type      IRQ_OUT,
  output var   logic [15:0]                RESET_ADDR,
  output var   logic                       IRQ_HELD
);
  if (ADDR_W != 16) begin : g_chk
    $error("ivp_top: ADDR_W must be 16");
  end

  // ==========================================================
  // fuse synchroniser
  ivp_pkg::fuse_type s1_r, s2_r, s3_r, fuse_r, fuse_nxt;

  always_comb begin
    fuse_nxt = fuse_r;
    if (s2_r == s3_r) begin
      fuse_nxt = s3_r;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s1_r   <= ivp_pkg::FUSE_RESET;
      s2_r   <= ivp_pkg::FUSE_RESET;
      s3_r   <= ivp_pkg::FUSE_RESET;
      fuse_r <= ivp_pkg::FUSE_RESET;
    end else begin
      s1_r   <= FUSES;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      fuse_r <= fuse_nxt;
    end
  end

  // ==========================================================
  // control register and unlock sequence
  logic [7:0]          ctl_r, ctl_nxt;
  ivp_pkg::unlock_type st_r, st_nxt;
  logic [2:0]          cnt_r, cnt_nxt;
  logic                wr_ctl;
  logic [7:0]          wr_byte;

  always_comb begin
    ctl_nxt = ctl_r;
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      ivp_pkg::ST_LOCKED: begin
        cnt_nxt = 3'h0;
      end
      ivp_pkg::ST_OPEN: begin
        if (cnt_r == 3'h1) begin
          ctl_nxt[ivp_pkg::CTL_UNLOCK_BIT] = 1'b0;
          st_nxt  = ivp_pkg::ST_LOCKED;
          cnt_nxt = 3'h0;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      ivp_pkg::ST_HOLD: begin
        if (INSTR_DONE) begin
          st_nxt = ivp_pkg::ST_LOCKED;
        end
      end
    endcase
    if (wr_ctl) begin
      ctl_nxt[ivp_pkg::CTL_DBG_BIT] = wr_byte[ivp_pkg::CTL_DBG_BIT];
      ctl_nxt[ivp_pkg::CTL_PULLUP_BIT] = wr_byte[ivp_pkg::CTL_PULLUP_BIT];
      if (wr_byte[ivp_pkg::CTL_UNLOCK_BIT]) begin
        ctl_nxt[ivp_pkg::CTL_UNLOCK_BIT] = 1'b1;
        st_nxt  = ivp_pkg::ST_OPEN;
        cnt_nxt = ivp_pkg::UNLOCK_CYCLES;
      end else if (st_r == ivp_pkg::ST_OPEN) begin
        ctl_nxt[ivp_pkg::CTL_SELECT_BIT] =
          wr_byte[ivp_pkg::CTL_SELECT_BIT];
        ctl_nxt[ivp_pkg::CTL_UNLOCK_BIT] = 1'b0;
        st_nxt  = ivp_pkg::ST_HOLD;
        cnt_nxt = 3'h0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctl_r <= ivp_pkg::CTL_RESET;
      st_r  <= ivp_pkg::ST_LOCKED;
      cnt_r <= 3'h0;
    end else begin
      ctl_r <= ctl_nxt;
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // vector placement and dispatch
  logic                  sel;
  logic                  held;
  logic                  blocked;
  logic [15:0]           boot_start;
  logic [15:0]           table_start;
  logic [15:0]           reset_nxt;
  ivp_pkg::dispatch_type disp_nxt;
  logic                  held_r;

  always_comb begin
    sel = ctl_r[ivp_pkg::CTL_SELECT_BIT];
    unique case (fuse_r.boot_size_fuses)
      2'h0:    boot_start = ivp_pkg::BOOT_START_SZ0;
      2'h1:    boot_start = ivp_pkg::BOOT_START_SZ1;
      2'h2:    boot_start = ivp_pkg::BOOT_START_SZ2;
      default: boot_start = ivp_pkg::BOOT_START_SZ3;
    endcase
    // fuse and lock bits read 0 when programmed
    reset_nxt = fuse_r.boot_reset_fuse ? ivp_pkg::RESET_WORD
                                       : boot_start;
    table_start = (sel ? boot_start : ivp_pkg::RESET_WORD)
                + ivp_pkg::TABLE_OFFSET;
    held = (st_r != ivp_pkg::ST_LOCKED) ||
           (wr_ctl && wr_byte[ivp_pkg::CTL_UNLOCK_BIT]);
    blocked = (sel && !fuse_r.app_section_boot_lock
                   && !EXEC_IN_BOOT) ||
              (!sel && !fuse_r.boot_section_boot_lock
                    && EXEC_IN_BOOT);
    disp_nxt = '0;
    for (int i = ivp_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (IRQ_REQ[i]) begin
        disp_nxt.num  = 5'(i + ivp_pkg::FIRST_IRQ_VECTOR);
        disp_nxt.addr = table_start
                      + ivp_pkg::VECTOR_STRIDE * 16'(i);
      end
    end
    // global enable is only read here, never written
    disp_nxt.valid = (|IRQ_REQ) && GLOBAL_IE && !held
                   && !blocked;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      IRQ_OUT    <= '0;
      RESET_ADDR <= ivp_pkg::RESET_WORD;
      held_r     <= 1'b0;
    end else begin
      IRQ_OUT    <= disp_nxt;
      RESET_ADDR <= reset_nxt;
      held_r     <= held;
    end
  end
  assign IRQ_HELD = held_r;

  // ==========================================================
  // AXI4-Lite slave
  logic        aw_h_r, aw_h_nxt, w_h_r, w_h_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [7:0]  wbyte_r, wbyte_nxt;
  logic        wlane_r, wlane_nxt;
  logic        awready_nxt, wready_nxt, bvalid_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic        arready_nxt, rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic        do_wr;

  always_comb begin
    aw_h_nxt   = aw_h_r;
    w_h_nxt    = w_h_r;
    awaddr_nxt = awaddr_r;
    wbyte_nxt  = wbyte_r;
    wlane_nxt  = wlane_r;
    bvalid_nxt = BVALID;
    bresp_nxt  = BRESP;
    rvalid_nxt = RVALID;
    rdata_nxt  = RDATA;
    rresp_nxt  = RRESP;
    wr_ctl     = 1'b0;
    wr_byte    = wbyte_nxt;
    if (BVALID && BREADY) begin
      bvalid_nxt = 1'b0;
    end
    if (AWVALID && AWREADY) begin
      aw_h_nxt   = 1'b1;
      awaddr_nxt = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_h_nxt   = 1'b1;
      wbyte_nxt = WDATA[7:0];
      wlane_nxt = WSTRB[0];
    end
    wr_byte = wbyte_nxt;
    do_wr   = aw_h_nxt && w_h_nxt && !BVALID;
    if (do_wr) begin
      aw_h_nxt   = 1'b0;
      w_h_nxt    = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = ivp_pkg::RESP_OKAY;
      unique case (awaddr_nxt)
        ivp_pkg::ADDR_CONTROL: wr_ctl = wlane_nxt;
        ivp_pkg::ADDR_STATUS, ivp_pkg::ADDR_PLACE: ;
        default: bresp_nxt = ivp_pkg::RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_h_nxt && !bvalid_nxt;
    wready_nxt  = !w_h_nxt && !bvalid_nxt;
    if (RVALID && RREADY) begin
      rvalid_nxt = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = ivp_pkg::RESP_OKAY;
      unique case (ARADDR)
        ivp_pkg::ADDR_CONTROL: rdata_nxt = {24'h0, ctl_r};
        ivp_pkg::ADDR_STATUS:
          rdata_nxt = {26'h0, held, cnt_r, st_r[2:1]};
        ivp_pkg::ADDR_PLACE: rdata_nxt = {reset_nxt, table_start};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = ivp_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      aw_h_r   <= 1'b0;
      w_h_r    <= 1'b0;
      awaddr_r <= 8'h00;
      wbyte_r  <= 8'h00;
      wlane_r  <= 1'b0;
      AWREADY  <= 1'b0;
      WREADY   <= 1'b0;
      BVALID   <= 1'b0;
      BRESP    <= ivp_pkg::RESP_OKAY;
      ARREADY  <= 1'b0;
      RVALID   <= 1'b0;
      RDATA    <= 32'h0;
      RRESP    <= ivp_pkg::RESP_OKAY;
    end else begin
      aw_h_r   <= aw_h_nxt;
      w_h_r    <= w_h_nxt;
      awaddr_r <= awaddr_nxt;
      wbyte_r  <= wbyte_nxt;
      wlane_r  <= wlane_nxt;
      AWREADY  <= awready_nxt;
      WREADY   <= wready_nxt;
      BVALID   <= bvalid_nxt;
      BRESP    <= bresp_nxt;
      ARREADY  <= arready_nxt;
      RVALID   <= rvalid_nxt;
      RDATA    <= rdata_nxt;
      RRESP    <= rresp_nxt;
    end
  end
endmodule
`default_nettype wire

//--- ivp_pkg.sv
// package: constants and types for the interrupt vector placement block
package ivp_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_PLACE   = 8'h08;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // ==========================================================
  // control register fields
  localparam int         CTL_UNLOCK_BIT = 0;
  localparam int         CTL_SELECT_BIT = 1;
  localparam int         CTL_PULLUP_BIT = 4;
  localparam int         CTL_DBG_BIT    = 7;
  localparam logic [7:0] CTL_RESET      = 8'h00;
  // ==========================================================
  // timing and table layout
  localparam logic [2:0]  UNLOCK_CYCLES    = 3'h4;
  localparam int          NUM_IRQ          = 28;
  localparam int          FIRST_IRQ_VECTOR = 2;
  localparam logic [15:0] RESET_WORD       = 16'h0000;
  localparam logic [15:0] TABLE_OFFSET     = 16'h0002;
  localparam logic [15:0] VECTOR_STRIDE    = 16'h0002;
  // boot section start (word address) per boot size fuse code
  localparam logic [15:0] BOOT_START_SZ0   = 16'h1800;
  localparam logic [15:0] BOOT_START_SZ1   = 16'h1c00;
  localparam logic [15:0] BOOT_START_SZ2   = 16'h1e00;
  localparam logic [15:0] BOOT_START_SZ3   = 16'h1f00;
  // ==========================================================
  // types
  typedef struct packed {
    logic       boot_reset_fuse;
    logic [1:0] boot_size_fuses;
    logic       app_section_boot_lock;
    logic       boot_section_boot_lock;
  } fuse_type;
  localparam fuse_type FUSE_RESET = 5'h1f;

  typedef struct packed {
    logic        valid;
    logic [4:0]  num;
    logic [15:0] addr;
  } dispatch_type;

  typedef enum logic [2:0] {
    ST_LOCKED = 3'b001,
    ST_OPEN   = 3'b010,
    ST_HOLD   = 3'b100
  } unlock_type;
endpackage

//--- ivp_top_sva.sv
// checker: port properties of the vector placement block
`timescale 1ns/1ps
`default_nettype none
module ivp_chk (
  input wire logic                         CLOCK,
  input wire logic                         RST,
  input wire logic                         ARVALID,
  input wire logic                         ARREADY,
  input wire logic [7:0]                   ARADDR,
  input wire logic                         RVALID,
  input wire logic [31:0]                  RDATA,
  input wire logic [1:0]                   RRESP,
  input wire logic [ivp_pkg::NUM_IRQ-1:0]  IRQ_REQ,
  input wire logic                         GLOBAL_IE,
  input wire logic                         INSTR_DONE,
  input wire ivp_pkg::dispatch_type        IRQ_OUT,
  input wire logic [15:0]                  RESET_ADDR,
  input wire logic                         IRQ_HELD
);
  // ==========================================
  // helpers
  logic [15:0] base;
  logic [3:0]  hc_r;
  logic [3:0]  hc_nxt;
  function automatic logic on_tbl(input logic [15:0] a);
    return a inside {16'h0000, ivp_pkg::BOOT_START_SZ0,
      ivp_pkg::BOOT_START_SZ1, ivp_pkg::BOOT_START_SZ2,
      ivp_pkg::BOOT_START_SZ3};
  endfunction
  assign base = IRQ_OUT.addr + 16'h0002 - {10'h000, IRQ_OUT.num, 1'b0};
  always_comb hc_nxt = (IRQ_HELD && !INSTR_DONE) ? hc_r + 4'h1 : 4'h0;
  always_ff @(posedge CLOCK) hc_r <= RST ? 4'h0 : hc_nxt;
  // ==========================================
  // properties
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  chk_tbl_base:
    assert property (IRQ_OUT.valid |-> on_tbl(base))
    else $error("vector address off table");
  chk_lowest_wins:
    assert property (IRQ_OUT.valid |-> ($past(IRQ_REQ) & (~$past(IRQ_REQ)
      + 28'h1)) == (28'h1 << (IRQ_OUT.num - 5'h2)))
    else $error("dispatched vector not lowest pending");
  chk_ie_gate:
    assert property (!$past(GLOBAL_IE) |-> !IRQ_OUT.valid)
    else $error("dispatch with interrupts off");
  chk_reset_word:
    assert property (on_tbl(RESET_ADDR))
    else $error("reset address not a section start");
  chk_held_bound:
    assert property (hc_r < 4'he)
    else $error("hold-off too long");
  chk_read_answer:
    assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  chk_ctl_zero:
    assert property (ARVALID && ARREADY && ARADDR == ivp_pkg::ADDR_CONTROL
      |=> (RDATA & 32'hffffff6c) == 32'h0)
    else $error("control reserved bits set");
  chk_unmapped:
    assert property (ARVALID && ARREADY && !(ARADDR inside {8'h00, 8'h04,
      8'h08}) |=> RRESP == ivp_pkg::RESP_SLVERR && RDATA == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind ivp_top ivp_chk u_chk (.CLOCK(CLOCK), .RST(RST), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RDATA(RDATA),
  .RRESP(RRESP), .IRQ_REQ(IRQ_REQ), .GLOBAL_IE(GLOBAL_IE),
  .INSTR_DONE(INSTR_DONE), .IRQ_OUT(IRQ_OUT), .RESET_ADDR(RESET_ADDR),
  .IRQ_HELD(IRQ_HELD));
`default_nettype wire

//--- ivp_core_model.sv
// core model: retires an instruction every second cycle while running
`timescale 1ns/1ps
`default_nettype none
module ivp_core_model (
  input  wire logic CLOCK,
  input  wire logic RST,
  input  wire logic run,
  output var  logic done
);
  logic ph_r;
  always_ff @(posedge CLOCK) ph_r <= RST ? 1'b0 : !ph_r;
  assign done = run && ph_r;
endmodule
`default_nettype wire

//--- interrupt_vector_placement_test.sv
// testbench: register and dispatch sequences for vector placement
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_placement_test;
  logic CLOCK = 0, RST = 1, AWVALID = 0, WVALID = 0, ARVALID = 0;
  logic BREADY = 1, RREADY = 1, GLOBAL_IE = 0, EXEC_IN_BOOT = 0, run = 1;
  logic [7:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, RDATA, d;
  logic [3:0] WSTRB = 4'hf;
  logic [27:0] IRQ_REQ = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, INSTR_DONE, IRQ_HELD;
  logic [1:0] BRESP, RRESP, r, b;
  logic [15:0] RESET_ADDR;
  logic [15:0] bs [4] = '{ivp_pkg::BOOT_START_SZ0, ivp_pkg::BOOT_START_SZ1,
    ivp_pkg::BOOT_START_SZ2, ivp_pkg::BOOT_START_SZ3};
  ivp_pkg::fuse_type FUSES = ivp_pkg::FUSE_RESET;
  ivp_pkg::dispatch_type IRQ_OUT;
  int errors = 0, total_checks = 0;
  always #10 CLOCK = ~CLOCK;
  ivp_top u_dut (.CLOCK(CLOCK), .RST(RST), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY),
    .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .FUSES(FUSES), .IRQ_REQ(IRQ_REQ), .GLOBAL_IE(GLOBAL_IE),
    .EXEC_IN_BOOT(EXEC_IN_BOOT), .INSTR_DONE(INSTR_DONE),
    .IRQ_OUT(IRQ_OUT), .RESET_ADDR(RESET_ADDR), .IRQ_HELD(IRQ_HELD));
  ivp_core_model u_core (.CLOCK(CLOCK), .RST(RST), .run(run),
    .done(INSTR_DONE));
  // ==========================================
  // tasks
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    b = BRESP;
  endtask
  task automatic rd(input logic [7:0] a);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    d = RDATA;
    r = RRESP;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic close_out;
    $display("errors=%0d checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // sequences
  initial begin
    wt(2);
    RST <= 1'b0;
    wt(8);
    rd(8'h00); ck(d, 32'h0);
    rd(8'h0c); ck(32'(r), 32'(ivp_pkg::RESP_SLVERR));
    wr(8'h0c, 32'h0); ck(32'(b), 32'(ivp_pkg::RESP_SLVERR));
    ck(32'(RESET_ADDR), 32'h0);
    wr(8'h00, 32'hff);
    ck(32'(b), 32'(ivp_pkg::RESP_OKAY));
    wt(8);
    ck(32'(IRQ_HELD), 32'h0);
    rd(8'h00); ck(d, 32'h90);
    GLOBAL_IE <= 1'b1;
    for (int n = 2; n < 30; n++) begin
      IRQ_REQ <= 28'hfffffff << (n - 2);
      wt(2);
      ck(32'(IRQ_OUT.num), n);
      ck(32'(IRQ_OUT.addr), 2 * (n - 1));
    end
    IRQ_REQ <= 28'h1;
    for (int s = 0; s < 4; s++) begin
      FUSES <= '{1'b0, s[1:0], 1'b1, 1'b1};
      wt(8);
      ck(32'(RESET_ADDR), 32'(bs[s]));
    end
    run <= 1'b0;
    wr(8'h00, 32'h01);
    wr(8'h00, 32'h02);
    wt(2);
    ck(32'(IRQ_HELD), 32'h1);
    ck(32'(IRQ_OUT.valid), 32'h0);
    run <= 1'b1;
    wt(6);
    ck(32'(IRQ_OUT.addr), 32'(bs[3]) + 2);
    rd(8'h00); ck(d, 32'h02);
    rd(8'h08); ck(d, 32'({bs[3], bs[3] + 16'h0002}));
    FUSES <= '{1'b0, 2'h3, 1'b0, 1'b1};
    wt(8);
    ck(32'(IRQ_OUT.valid), 32'h0);
    EXEC_IN_BOOT <= 1'b1;
    wt(2);
    ck(32'(IRQ_OUT.valid), 32'h1);
    wr(8'h00, 32'h01);
    wr(8'h00, 32'h00);
    FUSES <= '{1'b0, 2'h3, 1'b1, 1'b0};
    wt(8);
    ck(32'(IRQ_OUT.valid), 32'h0);
    EXEC_IN_BOOT <= 1'b0;
    wt(2);
    ck(32'(IRQ_OUT.addr), 32'h2);
    ck(32'(IRQ_OUT.valid), 32'h1);
    close_out;
  end
  initial begin
    wt(3000);
    errors++;
    close_out;
  end
endmodule
`default_nettype wire
